// >>> core/dio_pkg.sv
`default_nettype none
// ----------------------------------------
// Shared constants for the buffered I/O port
// ----------------------------------------
package dio_pkg;
  // Channel count equals the accumulator width
  localparam int CH_N = 12;
  // Clock and instruction pacing
  localparam int CLK_PERIOD_NS = 8;
  localparam int INSTR_TIME_NS = 1200;
  localparam int INSTR_CYC_DEF = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFF_IOT = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_IMASK = 8'h0C;
  localparam logic [7:0] OFF_DEVSEL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_OUTPUT = 8'h18;
  // Instruction word layout: code above the accumulator
  localparam int IOT_CODE_LSB = 12;
  localparam logic [2:0] IOT_GROUP = 3'h6;
  localparam logic [2:0] IOT_UNIT = 3'h5;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Reset values
  localparam logic [11:0] MODE_RST = 12'h000;
  localparam logic [11:0] IMASK_RST = 12'hFFF;
  localparam logic [2:0] DEVSEL_RST = 3'h0;
  localparam logic [11:0] OUT_N_RST = 12'hFFF;
  // Low octal digit of the instruction code
  typedef enum logic [2:0] {
    OP_INT_DIS = 3'h0,
    OP_INT_EN = 3'h1,
    OP_SKIP = 3'h2,
    OP_CLR_IN = 3'h3,
    OP_RD_IN = 3'h4,
    OP_CLR_OUT = 3'h5,
    OP_SET_OUT = 3'h6,
    OP_RD_OUT = 3'h7
  } iot_op_t;
  // Bus sequencer, Gray along idle-exec-wait
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_EXEC = 2'h1,
    BUS_WAIT = 2'h3
  } bus_state_t;
endpackage
`default_nettype wire

// >>> core/dio_port.sv
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dio_port #(
  parameter int INSTR_CYC = dio_pkg::INSTR_CYC_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [dio_pkg::CH_N-1:0] in_lines_n,
  output logic [dio_pkg::CH_N-1:0] out_lines_n,
  output logic irq_req,
  output logic skip_req
);
  import dio_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Pacing check needs eight stalled edges and a delay range of at most 1000
  if (INSTR_CYC < 9 || INSTR_CYC > 1000) begin : g_chk
    $error("dio_port: INSTR_CYC out of range");
  end
  // Cycles from the eighth stalled edge to the first ready edge
  localparam int PACE_N = INSTR_CYC - 7;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  bus_state_t state_r, state_nxt;
  logic [15:0] cnt_r;
  logic [31:0] hrdata_r;
  logic hready_r;
  logic hresp_r;
  logic we_mode_r, we_imask_r, we_devsel_r;
  logic [11:0] mode_r;
  logic [11:0] imask_r;
  logic [2:0] devsel_r;
  logic [11:0] out_r, out_nxt;
  logic [11:0] out_n_r;
  logic ien_r, ien_nxt;
  logic irq_r;
  logic skip_r;
  logic [11:0] res_data_r;
  logic res_skip_r;
  logic res_sel_r;
  logic [11:0] cap_w;
  logic [11:0] fall_w;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a == {24'h000000, off});
  endfunction

  // ----------------------------------------
  // Address phase decode
  // ----------------------------------------
  // Only whole-word accesses reach a register; others are ignored and leave the read data unchanged
  wire addr_ph = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  wire wr_take = addr_ph & hwrite;
  wire rd_take = addr_ph & ~hwrite;
  wire iot_take = wr_take & hit(haddr, OFF_IOT);

  // ----------------------------------------
  // Instruction decode, valid in the exec cycle
  // ----------------------------------------
  wire [11:0] code_w = hwdata[IOT_CODE_LSB+11:IOT_CODE_LSB];
  wire [11:0] ac_w = hwdata[11:0];
  wire [2:0] op_w = code_w[2:0];
  wire sel_w = (code_w[11:9] == IOT_GROUP) & (code_w[8:6] == IOT_UNIT)
               & (code_w[5:3] == devsel_r);
  wire exec_w = (state_r == BUS_EXEC) & sel_w;
  wire op_int_dis = exec_w & (op_w == OP_INT_DIS);
  wire op_int_en = exec_w & (op_w == OP_INT_EN);
  wire op_skip = exec_w & (op_w == OP_SKIP);
  wire op_clr_in = exec_w & (op_w == OP_CLR_IN);
  wire op_rd_in = exec_w & (op_w == OP_RD_IN);
  wire op_clr_out = exec_w & (op_w == OP_CLR_OUT);
  wire op_set_out = exec_w & (op_w == OP_SET_OUT);
  wire op_rd_out = exec_w & (op_w == OP_RD_OUT);

  // ----------------------------------------
  // Input path
  // ----------------------------------------
  edge_capture #(
    .WIDTH(CH_N)
  ) u_cap (
    .mclk(mclk),
    .srst(srst),
    .line_n(in_lines_n),
    .clr(op_clr_in ? ac_w : 12'h000),
    .cap(cap_w),
    .fall(fall_w)
  );

  // Capture keeps running on level bits; clear them before going back to edge
  // Level bits bypass the capture flop and show the live line inverted
  wire [11:0] eff_in = (mode_r & ~in_lines_n) | (~mode_r & cap_w);
  // Masked-off bits carry data only
  wire flag_w = |(eff_in & imask_r);

  // ----------------------------------------
  // Output and enable next values
  // ----------------------------------------
  // Set and clear never coincide: one instruction per exec cycle
  assign out_nxt = op_set_out ? (out_r | ac_w) :
                   op_clr_out ? (out_r & ~ac_w) : out_r;
  assign ien_nxt = op_int_en ? 1'b1 : op_int_dis ? 1'b0 : ien_r;

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  wire [31:0] rd_word =
    hit(haddr, OFF_RESULT) ? {18'h0, res_sel_r, res_skip_r, res_data_r} :
    hit(haddr, OFF_MODE) ? {20'h0, mode_r} :
    hit(haddr, OFF_IMASK) ? {20'h0, imask_r} :
    hit(haddr, OFF_DEVSEL) ? {29'h0, devsel_r} :
    hit(haddr, OFF_STATUS) ? {18'h0, ien_r, flag_w, eff_in} :
    hit(haddr, OFF_OUTPUT) ? {20'h0, out_r} : 32'h0;

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  // An instruction write stalls for one instruction time so that
  // back-to-back set/clear still yields a visible pulse
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BUS_IDLE: state_nxt = iot_take ? BUS_EXEC : BUS_IDLE;
      BUS_EXEC: state_nxt = BUS_WAIT;
      BUS_WAIT: state_nxt = (cnt_r == 16'(INSTR_CYC - 1)) ? BUS_IDLE : BUS_WAIT;
      default: state_nxt = BUS_IDLE;
    endcase
  end

  // State, pacing counter and ready
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= BUS_IDLE;
      cnt_r <= 16'h0000;
      hready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_r == BUS_EXEC) ? 16'h0001 : cnt_r + 16'h0001;
      hready_r <= (state_nxt == BUS_IDLE);
    end
  end

  // Read data and response; reads never wait
  always_ff @(posedge mclk) begin
    if (srst) begin
      hrdata_r <= 32'h00000000;
      hresp_r <= 1'b0;
    end else begin
      hrdata_r <= rd_take ? rd_word : hrdata_r;
      hresp_r <= 1'b0;
    end
  end

  // Configuration writes land two edges after their address phase
  always_ff @(posedge mclk) begin
    if (srst) begin
      we_mode_r <= 1'b0;
      we_imask_r <= 1'b0;
      we_devsel_r <= 1'b0;
      mode_r <= MODE_RST;
      imask_r <= IMASK_RST;
      devsel_r <= DEVSEL_RST;
    end else begin
      we_mode_r <= wr_take & hit(haddr, OFF_MODE);
      we_imask_r <= wr_take & hit(haddr, OFF_IMASK);
      we_devsel_r <= wr_take & hit(haddr, OFF_DEVSEL);
      if (we_mode_r) begin
        mode_r <= hwdata[11:0];
      end
      if (we_imask_r) begin
        imask_r <= hwdata[11:0];
      end
      if (we_devsel_r) begin
        devsel_r <= hwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Device state
  // ----------------------------------------
  // Pin register holds the inverse so the lines sink for a one
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_r <= 12'h000;
      out_n_r <= OUT_N_RST;
      ien_r <= 1'b0;
      irq_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      out_n_r <= ~out_nxt;
      ien_r <= ien_nxt;
      irq_r <= flag_w & ien_r;
      skip_r <= op_skip & flag_w;
    end
  end

  // Answer of the last instruction, read back through the result word
  always_ff @(posedge mclk) begin
    if (srst) begin
      res_data_r <= 12'h000;
      res_skip_r <= 1'b0;
      res_sel_r <= 1'b0;
    end else if (state_r == BUS_EXEC) begin
      res_sel_r <= sel_w;
      res_skip_r <= op_skip & flag_w;
      res_data_r <= op_rd_in ? eff_in : op_rd_out ? out_r : res_data_r;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign out_lines_n = out_n_r;
  assign irq_req = irq_r;
  assign skip_req = skip_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_out_polarity: assert property (@(posedge mclk) disable iff (srst)
    out_lines_n == ~out_r)
    else $error("output pins not the inverse of the output register");

  a_out_hold: assert property (@(posedge mclk) disable iff (srst)
    !(op_set_out | op_clr_out) |=> $stable(out_r))
    else $error("output register changed without an output instruction");

  a_edge_set: assert property (@(posedge mclk) disable iff (srst)
    (fall_w & ~mode_r) != 12'h000 |=> (cap_w & $past(fall_w)) == $past(fall_w))
    else $error("falling edge not captured");

  a_level_bypass: assert property (@(posedge mclk) disable iff (srst)
    (eff_in & mode_r) == (~in_lines_n & mode_r))
    else $error("level bit does not follow its line");

  a_clr_in_sel: assert property (@(posedge mclk) disable iff (srst)
    op_clr_in |=> (cap_w & $past(ac_w) & ~$past(fall_w)) == 12'h000)
    else $error("selected input bit not cleared");

  a_clr_in_keep: assert property (@(posedge mclk) disable iff (srst)
    op_clr_in |=> ((cap_w ^ $past(cap_w)) & ~$past(ac_w) & ~$past(fall_w)) == 12'h000)
    else $error("unselected input bit changed on clear");

  a_cap_sticky: assert property (@(posedge mclk) disable iff (srst)
    !op_clr_in |=> (cap_w & $past(cap_w)) == $past(cap_w))
    else $error("captured bit lost without a clear");

  a_out_clr: assert property (@(posedge mclk) disable iff (srst)
    op_clr_out |=> (out_r & $past(ac_w)) == 12'h000 && out_lines_n == ~out_r)
    else $error("clear-outputs left a selected bit set");

  a_out_set: assert property (@(posedge mclk) disable iff (srst)
    op_set_out |=> out_r == ($past(out_r) | $past(ac_w)))
    else $error("set-outputs result wrong");

  a_iot_pace: assert property (@(posedge mclk) disable iff (srst)
    iot_take |=> !hreadyout [*8] ##[PACE_N:PACE_N] (hreadyout && !$past(hreadyout)))
    else $error("instruction stall not one instruction time");

  a_rd_in: assert property (@(posedge mclk) disable iff (srst)
    op_rd_in |=> res_data_r == $past(eff_in))
    else $error("read-inputs returned wrong value");

  a_ien_set: assert property (@(posedge mclk) disable iff (srst)
    op_int_en |=> ien_r ##1 (irq_req == $past(flag_w)))
    else $error("interrupt enable not effective");

  a_skip_flag: assert property (@(posedge mclk) disable iff (srst)
    (state_r == BUS_EXEC) |=> skip_req == ($past(op_skip) & $past(flag_w)))
    else $error("skip does not match the flag");

  a_masked_bits: assert property (@(posedge mclk) disable iff (srst)
    (eff_in & imask_r) == 12'h000 |=> !irq_req)
    else $error("masked input raised an interrupt");

  a_dev_select: assert property (@(posedge mclk) disable iff (srst)
    (state_r == BUS_EXEC) && !sel_w |=> $stable(out_r) && !skip_req && !res_sel_r)
    else $error("instruction for another unit acted");

  a_ien_clear: assert property (@(posedge mclk) disable iff (srst)
    op_int_dis |=> !ien_r ##1 !irq_req)
    else $error("interrupt disable not effective");

  a_rd_out: assert property (@(posedge mclk) disable iff (srst)
    op_rd_out |=> res_data_r == $past(out_r))
    else $error("read-outputs returned wrong value");

  a_clr_out_keep: assert property (@(posedge mclk) disable iff (srst)
    op_clr_out |=> ((out_r ^ $past(out_r)) & ~$past(ac_w)) == 12'h000)
    else $error("clear-outputs changed an unselected bit");

  a_skip_source: assert property (@(posedge mclk) disable iff (srst)
    skip_req |-> $past(op_skip) && $past(flag_w))
    else $error("skip raised without a skip on a set flag");

  a_skip_masked: assert property (@(posedge mclk) disable iff (srst)
    op_skip && (eff_in & imask_r) == 12'h000 |=> !skip_req)
    else $error("masked input caused a skip");

  a_irq_gate: assert property (@(posedge mclk) disable iff (srst)
    !ien_r |=> !irq_req)
    else $error("interrupt request without enable");

  a_ien_hold: assert property (@(posedge mclk) disable iff (srst)
    !(op_int_en || op_int_dis) |=> $stable(ien_r))
    else $error("interrupt enable changed without an instruction");

  a_reset_state: assert property (@(posedge mclk)
    srst |=> out_r == 12'h000 && cap_w == 12'h000 && !ien_r && out_lines_n == OUT_N_RST)
    else $error("reset did not clear device state");
endmodule // dio_port
`default_nettype wire

// >>> core/edge_capture.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Falling-edge capture flip-flops
// ----------------------------------------
module edge_capture #(
  parameter int WIDTH = dio_pkg::CH_N
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] line_n,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] cap,
  output logic [WIDTH-1:0] fall
);
  import dio_pkg::*;

  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] cap_r;

  if (WIDTH < 1) begin : g_chk
    $error("edge_capture: WIDTH must be at least 1");
  end

  // High-to-low seen between two samples
  assign fall = prev_r & ~line_n;
  assign cap = cap_r;

  // Idle lines sit high, so prev starts high to avoid a false edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_r <= {WIDTH{1'b1}};
      cap_r <= '0;
    end else begin
      prev_r <= line_n;
      cap_r <= fall | (cap_r & ~clr);
    end
  end
endmodule // edge_capture
`default_nettype wire

// >>> sim/ext_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// External event sources and output load
// ----------------------------------------
module ext_model (
  input wire logic mclk,
  input wire logic [11:0] out_lines_n,
  output logic [11:0] in_lines_n,
  output int low_cyc
);
  int cnt = 0;
  // Pull-ups keep released lines high
  initial begin
    in_lines_n = 12'hFFF;
    low_cyc = 0;
  end
  // Event pulse, low 8 cycles so it outlasts 50 ns
  task automatic fire(input logic [11:0] m);
    @(posedge mclk) in_lines_n <= ~m;
    repeat (8) @(posedge mclk);
    in_lines_n <= 12'hFFF;
  endtask
  // Static level for level-mode bits
  task automatic hold(input logic [11:0] m);
    @(posedge mclk) in_lines_n <= ~m;
  endtask
  // Load measures active-low width on bit 0
  always @(posedge mclk) begin
    if (out_lines_n[0] === 1'b0) begin
      cnt <= cnt + 1;
    end else begin
      if (cnt != 0) begin
        low_cyc <= cnt;
      end
      cnt <= 0;
    end
  end
endmodule // ext_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dio_pkg::*;
  localparam int IC = 16;
  logic mclk, srst, hsel, hwrite, hreadyout, hresp, irq_req, skip_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, dx;
  logic [11:0] in_lines_n, out_lines_n;
  int low_cyc, fails = 0, num_checks = 0, skips = 0;
  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  dio_port #(.INSTR_CYC(IC)) u_dio_port (.mclk(mclk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .in_lines_n(in_lines_n), .out_lines_n(out_lines_n), .irq_req(irq_req),
    .skip_req(skip_req));
  ext_model u_ext_model (.mclk(mclk), .out_lines_n(out_lines_n),
    .in_lines_n(in_lines_n), .low_cyc(low_cyc));
  // Skip is a one-cycle pulse, so count it
  always @(posedge mclk) begin
    if (skip_req === 1'b1) begin
      skips++;
    end
  end
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Single word transfer; no wait count assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 400);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 400);
    q = hrdata;
    if (n >= 400) begin
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic iot(input logic [2:0] op, input logic [11:0] ac);
    wr(OFF_IOT, {8'h00, IOT_GROUP, IOT_UNIT, dx, op, ac});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    report_and_stop();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    dx = 3'h0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    chk({20'h0, out_lines_n}, 32'hFFF);
    chk({31'h0, irq_req}, 32'h0);
    rdc(OFF_STATUS, 32'h0);
    $display("reset test done");
    iot(OP_SET_OUT, 12'hA5A);
    chk({20'h0, out_lines_n}, {20'h0, ~12'hA5A});
    iot(OP_SET_OUT, 12'h00F);
    iot(OP_CLR_OUT, 12'h00A);
    wr(OFF_MODE, 32'h0);
    rdc(OFF_OUTPUT, 32'hA55);
    iot(OP_RD_OUT, 12'h000);
    rdc(OFF_RESULT, 32'h2A55);
    iot(OP_CLR_OUT, 12'hFFF);
    chk({20'h0, out_lines_n}, 32'hFFF);
    iot(OP_SET_OUT, 12'h001);
    iot(OP_CLR_OUT, 12'h001);
    repeat (2) @(posedge mclk);
    chk({31'h0, low_cyc >= IC + 1 && low_cyc <= IC + 3}, 32'h1);
    $display("output test done");
    u_ext_model.fire(12'h00C);
    repeat (3) @(posedge mclk);
    rdc(OFF_STATUS, 32'h100C);
    iot(OP_RD_IN, 12'h000);
    rdc(OFF_RESULT, 32'h200C);
    iot(OP_SKIP, 12'h000);
    rdc(OFF_RESULT, 32'h300C);
    iot(OP_CLR_IN, 12'h004);
    rdc(OFF_STATUS, 32'h1008);
    iot(OP_CLR_IN, 12'hFFF);
    iot(OP_SKIP, 12'h000);
    rdc(OFF_RESULT, 32'h200C);
    chk(32'(skips), 32'h1);
    $display("edge input test done");
    iot(OP_INT_EN, 12'h000);
    u_ext_model.fire(12'h001);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_req}, 32'h1);
    iot(OP_INT_DIS, 12'h000);
    chk({31'h0, irq_req}, 32'h0);
    wr(OFF_IMASK, 32'hFFE);
    iot(OP_INT_EN, 12'h000);
    chk({31'h0, irq_req}, 32'h0);
    rdc(OFF_STATUS, 32'h2001);
    iot(OP_CLR_IN, 12'hFFF);
    wr(OFF_IMASK, 32'hFFF);
    iot(OP_INT_DIS, 12'h000);
    $display("interrupt test done");
    wr(OFF_MODE, 32'hFFF);
    u_ext_model.hold(12'h0F0);
    repeat (3) @(posedge mclk);
    iot(OP_RD_IN, 12'h000);
    rdc(OFF_RESULT, 32'h20F0);
    u_ext_model.hold(12'h000);
    repeat (3) @(posedge mclk);
    rdc(OFF_STATUS, 32'h0);
    // Level bits still ran through capture, so drop those stale events
    wr(OFF_MODE, 32'h0);
    iot(OP_CLR_IN, 12'hFFF);
    rdc(OFF_STATUS, 32'h0);
    $display("level input test done");
    for (int x = 0; x < 8; x++) begin
      wr(OFF_DEVSEL, 32'(x));
      dx = 3'(x + 1);
      iot(OP_SET_OUT, 12'h800);
      rdc(OFF_OUTPUT, 32'h0);
      dx = 3'(x);
      iot(OP_SET_OUT, 12'h800);
      rdc(OFF_OUTPUT, 32'h800);
      iot(OP_CLR_OUT, 12'h800);
    end
    wr(8'h1C, 32'hFFFFFFFF);
    rdc(8'h1C, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rdc(OFF_OUTPUT, 32'h0);
    $display("device code test done");
    // Load outputs, interrupt enable, device code and an input event, then reset in mid-run with the bus idle
    iot(OP_SET_OUT, 12'hFFF);
    iot(OP_INT_EN, 12'h000);
    u_ext_model.fire(12'h002);
    repeat (3) @(posedge mclk);
    rdc(OFF_STATUS, 32'h3002);
    chk({31'h0, irq_req}, 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    chk({20'h0, out_lines_n}, 32'hFFF);
    chk({31'h0, irq_req}, 32'h0);
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_DEVSEL, 32'h0);
    dx = 3'h0;
    iot(OP_SET_OUT, 12'h001);
    rdc(OFF_OUTPUT, 32'h1);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
